//--- core/cofs_pkg.sv
// constants for the integrity and overcurrent fault status bank
// assumes a 16-bit register port with word addresses from the serial decoder
package cofs_pkg;
  localparam int DATA_W = 16;
  localparam int ADDR_W = 8;
  localparam logic [7:0] ADDR_INTEGRITY = 8'h05;
  localparam logic [7:0] ADDR_OVERCURRENT = 8'h06;
  localparam logic [15:0] RST_INTEGRITY = 16'hEC00;
  localparam logic [15:0] RST_OVERCURRENT = 16'h000F;
  // integrity register field positions
  localparam int BIT_MAP1 = 15;
  localparam int BIT_MAP2 = 14;
  localparam int BIT_MAP3 = 13;
  localparam int BIT_MEM = 11;
  localparam int BIT_BANK = 10;
  // overcurrent register field positions
  localparam int BIT_A_HIGH = 3;
  localparam int BIT_A_LOW = 2;
  localparam int BIT_B_HIGH = 1;
  localparam int BIT_B_LOW = 0;
  localparam int OC_FLAGS = 4;
  localparam int MAP_FLAGS = 4;
  localparam logic [15:0] ZERO16 = 16'h0000;
endpackage : cofs_pkg

//--- core/cofs_flag.sv
// one sticky active-low fault flag with write-one-to-clear
// assumes fault pulses and clear strobes are synchronous to i_mclk
`timescale 1ns/1ns
module cofs_flag (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // events
  input wire logic i_fault,
  input wire logic i_clear,
  // state
  output logic o_flag_n
);
  logic next_flag_n;

  // a fault in the clear cycle wins, so no event is lost
  assign next_flag_n = i_fault ? 1'b0 : (i_clear ? 1'b1 : o_flag_n);

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_flag_n <= 1'b1;
    end else begin
      o_flag_n <= next_flag_n;
    end
  end
endmodule : cofs_flag

//--- core/cofs_status_bank.sv
// integrity and overcurrent fault status registers, read and cleared by the host
// assumes the serial decoder hands over single-cycle read and write strobes
// Notes on behaviour
// - section-one map mismatch clears bit 15
// - section-two map mismatch clears bit 14
// - section-three map mismatch clears bit 13
// - flags active low, sticky, write one restores
// - internal memory mismatch clears bit 11
// - bit 10 shows bank loaded at reset
// - channel A above high threshold clears bit 3
// - channel A below low threshold clears bit 2
// - channel B above high threshold clears bit 1
// - channel B below low threshold clears bit 0
// - integrity register resets to EC00h
// - overcurrent register resets to 000Fh
`timescale 1ns/1ns
module cofs_status_bank (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // register port
  input wire logic [cofs_pkg::ADDR_W-1:0] i_addr,
  input wire logic i_wr,
  input wire logic [cofs_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_rd,
  output logic [cofs_pkg::DATA_W-1:0] o_rdata,
  output logic o_rvalid,
  // fault events, one-cycle pulses or levels, and the backup bank strap
  input wire logic i_map1_mismatch,
  input wire logic i_map2_mismatch,
  input wire logic i_map3_mismatch,
  input wire logic i_mem_mismatch,
  input wire logic i_backup_bank,
  input wire logic i_a_above_high,
  input wire logic i_a_below_low,
  input wire logic i_b_above_high,
  input wire logic i_b_below_low,
  // summary toward the top status register
  output logic o_digital_fault_n
);
  import cofs_pkg::*;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  // one compare per register, shared by the write strobe and the read mux
  function automatic logic addr_hits(input logic [ADDR_W-1:0] addr,
                                     input logic [ADDR_W-1:0] target);
    return addr == target;
  endfunction : addr_hits

  logic sel_integrity;
  logic sel_overcurrent;
  logic sel_unmapped;
  logic wr_integrity;
  logic wr_overcurrent;
  assign sel_integrity = addr_hits(i_addr, ADDR_INTEGRITY);
  assign sel_overcurrent = addr_hits(i_addr, ADDR_OVERCURRENT);
  assign sel_unmapped = !(sel_integrity || sel_overcurrent);
  assign wr_integrity = i_wr && sel_integrity;
  assign wr_overcurrent = i_wr && sel_overcurrent;

  // ----------------------------------------------------------------
  // integrity flags: map1, map2, map3, memory
  // ----------------------------------------------------------------
  logic [MAP_FLAGS-1:0] map_fault;
  logic [MAP_FLAGS-1:0] map_clear;
  logic [MAP_FLAGS-1:0] map_flag_n;
  assign map_fault = {i_map1_mismatch, i_map2_mismatch, i_map3_mismatch, i_mem_mismatch};
  logic wr_one_map1;
  logic wr_one_map2;
  logic wr_one_map3;
  logic wr_one_mem;
  assign wr_one_map1 = i_wdata[BIT_MAP1];
  assign wr_one_map2 = i_wdata[BIT_MAP2];
  assign wr_one_map3 = i_wdata[BIT_MAP3];
  assign wr_one_mem = i_wdata[BIT_MEM];
  assign map_clear = {MAP_FLAGS{wr_integrity}} &
    {wr_one_map1, wr_one_map2, wr_one_map3, wr_one_mem};

  // ----------------------------------------------------------------
  // overcurrent flags: a high, a low, b high, b low
  // ----------------------------------------------------------------
  logic [OC_FLAGS-1:0] oc_fault;
  logic [OC_FLAGS-1:0] oc_clear;
  logic [OC_FLAGS-1:0] oc_flag_n;
  assign oc_fault = {i_a_above_high, i_a_below_low, i_b_above_high, i_b_below_low};
  logic wr_one_a_high;
  logic wr_one_a_low;
  logic wr_one_b_high;
  logic wr_one_b_low;
  assign wr_one_a_high = i_wdata[BIT_A_HIGH];
  assign wr_one_a_low = i_wdata[BIT_A_LOW];
  assign wr_one_b_high = i_wdata[BIT_B_HIGH];
  assign wr_one_b_low = i_wdata[BIT_B_LOW];
  assign oc_clear = {OC_FLAGS{wr_overcurrent}} &
    {wr_one_a_high, wr_one_a_low, wr_one_b_high, wr_one_b_low};

  // one flag cell per bit, all alike, so set and clear priority is uniform
  genvar g;
  generate
    for (g = 0; g < MAP_FLAGS; g++) begin : g_map
      cofs_flag u_flag (
        .i_mclk(i_mclk),
        .i_rst(i_rst),
        .i_fault(map_fault[g]),
        .i_clear(map_clear[g]),
        .o_flag_n(map_flag_n[g])
      );
    end
    for (g = 0; g < OC_FLAGS; g++) begin : g_oc
      cofs_flag u_flag (
        .i_mclk(i_mclk),
        .i_rst(i_rst),
        .i_fault(oc_fault[g]),
        .i_clear(oc_clear[g]),
        .o_flag_n(oc_flag_n[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // flag fields by name
  // ----------------------------------------------------------------
  // vectors run msb first in register order, so index 3 is the top field
  logic map1_flag_n;
  logic map2_flag_n;
  logic map3_flag_n;
  logic mem_flag_n;
  assign map1_flag_n = map_flag_n[3];
  assign map2_flag_n = map_flag_n[2];
  assign map3_flag_n = map_flag_n[1];
  assign mem_flag_n = map_flag_n[0];
  logic a_high_flag_n;
  logic a_low_flag_n;
  logic b_high_flag_n;
  logic b_low_flag_n;
  assign a_high_flag_n = oc_flag_n[3];
  assign a_low_flag_n = oc_flag_n[2];
  assign b_high_flag_n = oc_flag_n[1];
  assign b_low_flag_n = oc_flag_n[0];

  // ----------------------------------------------------------------
  // bank indicator, caught after reset release
  // ----------------------------------------------------------------
  // reset value shows primary bank; first clocked cycle latches the strap once
  logic bank_primary;
  logic bank_taken;
  logic next_bank_primary;
  // the strap is looked at once; later changes on the pin do not move the bit
  assign next_bank_primary = bank_taken ? bank_primary : !i_backup_bank;

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      bank_primary <= 1'b1;
      bank_taken <= 1'b0;
    end else begin
      bank_primary <= next_bank_primary;
      bank_taken <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // readback
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] integrity_word;
  logic [DATA_W-1:0] overcurrent_word;
  logic [DATA_W-1:0] next_rdata;
  logic next_rvalid;
  always_comb begin
    integrity_word = ZERO16;
    integrity_word[BIT_MAP1] = map1_flag_n;
    integrity_word[BIT_MAP2] = map2_flag_n;
    integrity_word[BIT_MAP3] = map3_flag_n;
    integrity_word[BIT_MEM] = mem_flag_n;
    integrity_word[BIT_BANK] = bank_primary;
    overcurrent_word = ZERO16;
    overcurrent_word[BIT_A_HIGH] = a_high_flag_n;
    overcurrent_word[BIT_A_LOW] = a_low_flag_n;
    overcurrent_word[BIT_B_HIGH] = b_high_flag_n;
    overcurrent_word[BIT_B_LOW] = b_low_flag_n;
  end
  // unmapped addresses read zero
  assign next_rdata = sel_unmapped ? ZERO16 :
                      (sel_integrity ? integrity_word : overcurrent_word);
  assign next_rvalid = i_rd;

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_rvalid <= 1'b0;
    end else begin
      o_rvalid <= next_rvalid;
    end
  end

  // data stands until the next read, so a slow host can still pick it up
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_rdata <= ZERO16;
    end else if (i_rd) begin
      o_rdata <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // summary toward the top status register
  // ----------------------------------------------------------------
  logic next_digital_fault_n;
  // bank bit left out: a backup bank is not a live fault
  assign next_digital_fault_n = map1_flag_n & map2_flag_n & map3_flag_n & mem_flag_n;

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_digital_fault_n <= 1'b1;
    end else begin
      o_digital_fault_n <= next_digital_fault_n;
    end
  end
endmodule : cofs_status_bank

//--- bench/cofs_status_bank_properties.sv
// port assertions for the fault status bank
// assumes one clock and an active-high reset
`timescale 1ns/1ns
module cofs_status_bank_properties (
  input wire logic i_mclk, i_rst, i_rd, i_map1_mismatch, i_mem_mismatch, i_a_above_high,
  input wire logic [7:0] i_addr,
  input wire logic [15:0] o_rdata,
  input wire logic o_rvalid, o_digital_fault_n
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  a_read_valid: assert property (i_rd |=> o_rvalid) else $error("no rvalid");
  a_valid_cause: assert property (o_rvalid |-> $past(i_rd)) else $error("stray rvalid");
  a_rdata_hold: assert property (!$past(i_rd) |-> $stable(o_rdata)) else $error("rdata moved");
  a_int_reserved: assert property (i_rd && i_addr == 8'h05 |=> !(o_rdata & 16'h13FF))
    else $error("reserved set");
  a_occ_reserved: assert property (i_rd && i_addr == 8'h06 |=> !o_rdata[15:4])
    else $error("reserved set");
  a_map1_flag: assert property (i_map1_mismatch ##1 i_rd && i_addr == 8'h05 |=> !o_rdata[15])
    else $error("map flag high");
  a_occ_flag: assert property (i_a_above_high ##1 i_rd && i_addr == 8'h06 |=> !o_rdata[3])
    else $error("high flag high");
  a_map_summary: assert property (i_map1_mismatch |=> ##1 !o_digital_fault_n)
    else $error("summary high");
  a_mem_summary: assert property (i_mem_mismatch |=> ##1 !o_digital_fault_n)
    else $error("summary high");
endmodule : cofs_status_bank_properties
bind cofs_status_bank cofs_status_bank_properties u_props (.i_mclk, .i_rst, .i_rd,
  .i_map1_mismatch, .i_mem_mismatch, .i_a_above_high, .i_addr, .o_rdata, .o_rvalid,
  .o_digital_fault_n);

//--- bench/cofs_host.sv
// host side of the register port
// assumes calls land just after a falling clock edge
`timescale 1ns/1ns
module cofs_host (
  output logic o_wr, o_rd,
  output logic [7:0] o_addr,
  output logic [15:0] o_wdata
);
  // a request holds until the next call, so strobes span one full edge
  task put(input logic w, r, input logic [7:0] a, input logic [15:0] d);
    {o_wr, o_rd, o_addr, o_wdata} = {w, r, a, d};
  endtask : put
endmodule : cofs_host

//--- bench/crc_and_overcurrent_fault_status_tb.sv
// self-checking bench for the fault status bank with a reference model
// assumes the package and host model are compiled first
`timescale 1ns/1ns
module crc_and_overcurrent_fault_status_tb;
  import cofs_pkg::*;
  logic i_mclk = 0, i_rst = 1, bk = 0, i_wr, i_rd, o_rvalid, o_dfn, sd;
  logic [7:0] i_addr, flt = 0;
  logic [15:0] i_wdata, o_rdata, m5, m6;
  logic [31:0] rs = 32'h16D4;
  int mismatches = 0, n_checks = 0;
  always #2 i_mclk = ~i_mclk;
  cofs_host host (.o_wr(i_wr), .o_rd(i_rd), .o_addr(i_addr), .o_wdata(i_wdata));
  cofs_status_bank dut (.i_mclk, .i_rst, .i_addr, .i_wr, .i_wdata, .i_rd, .o_rdata,
    .o_rvalid, .i_map1_mismatch(flt[0]), .i_map2_mismatch(flt[1]), .i_map3_mismatch(flt[2]),
    .i_mem_mismatch(flt[3]), .i_backup_bank(bk), .i_a_above_high(flt[4]),
    .i_a_below_low(flt[5]), .i_b_above_high(flt[6]), .i_b_below_low(flt[7]),
    .o_digital_fault_n(o_dfn));
  function logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    return v ^ (v << 5);
  endfunction : xs
  task chk(input string n, input logic [15:0] s, e);
    n_checks++;
    if (s !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task complete_run;
    if (mismatches == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : complete_run
  // summary lags the flags one edge, so it is checked against the older model
  task cyc(input logic [7:0] f, input logic w, r, input logic [7:0] a, input logic [15:0] d);
    logic [15:0] e;
    chk("summary", o_dfn, sd);
    flt = f;
    host.put(w, r, a, d);
    e = a == ADDR_INTEGRITY ? m5 : a == ADDR_OVERCURRENT ? m6 : ZERO16;
    sd = &{m5[15:13], m5[11]};
    @(negedge i_mclk);
    if (w && a == ADDR_INTEGRITY) m5 |= d & 16'hE800;
    if (w && a == ADDR_OVERCURRENT) m6 |= d & 16'h000F;
    m5 &= ~{f[0], f[1], f[2], 1'b0, f[3], 11'h0};
    m6 &= ~{12'h0, f[4], f[5], f[6], f[7]};
    if (r) chk("rdata", o_rdata, e);
    chk("rvalid", o_rvalid, r);
  endtask : cyc
  initial begin
    logic [7:0] a;
    host.put(0, 0, 0, 0);
    {m5, m6, sd} = {RST_INTEGRITY, RST_OVERCURRENT, 1'b1};
    repeat (20) @(negedge i_mclk);
    i_rst = 0;
    cyc(0, 0, 1, ADDR_INTEGRITY, 0);
    cyc(0, 0, 1, ADDR_OVERCURRENT, 0);
    for (int i = 0; i < 8; i++) begin
      a = i < 4 ? ADDR_INTEGRITY : ADDR_OVERCURRENT;
      cyc(8'h01 << i, 0, 0, a, 0);
      cyc(8'h01 << i, 1, 1, a, 16'hFFFF);
      cyc(0, 1, 1, a, 16'h0);
      cyc(0, 1, 1, a, 16'hFFFF);
      cyc(0, 0, 1, a, 0);
    end
    repeat (300) begin
      rs = xs(rs);
      cyc(rs[7:0] & rs[15:8] & rs[23:16], rs[24], 1, 8'h04 + rs[26:25], rs[31:16]);
    end
    i_rst = 1;
    bk = 1;
    {m5, m6, sd} = {RST_INTEGRITY & 16'hFBFF, RST_OVERCURRENT, 1'b1};
    repeat (2) @(negedge i_mclk);
    i_rst = 0;
    cyc(0, 0, 0, 0, 0);
    cyc(0, 0, 1, ADDR_INTEGRITY, 0);
    cyc(0, 0, 0, 0, 0);
    complete_run;
  end
  initial begin
    repeat (5000) @(posedge i_mclk);
    mismatches++;
    complete_run;
  end
endmodule : crc_and_overcurrent_fault_status_tb
